/* verilog/ssp_pkg.sv */
// Shared constants and types of the serial command port.
package ssp_pkg;

	// ------------------------------------------------------------------
	// Command byte values
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_LOAD_ADDRESS     = 8'h20;
	localparam logic [7:0] CMD_REGISTER_READ    = 8'h6d;
	localparam logic [7:0] CMD_REGISTER_WRITE   = 8'h2d;
	localparam logic [7:0] CMD_FIFO_STREAM_READ = 8'h5f;

	// ------------------------------------------------------------------
	// Byte positions counted from the falling edge of chip select
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_HIGH_BYTE  = 4'h1;
	localparam logic [3:0] ADDR_LOW_BYTE   = 4'h2;
	localparam logic [3:0] READ_DATA_BYTE  = 4'h2;
	localparam logic [3:0] FIFO_DATA_BYTE  = 4'h7;
	localparam logic [3:0] WRITE_NARROW_END = 4'h2;
	localparam logic [3:0] WRITE_WIDE_END  = 4'h4;
	localparam logic [3:0] BYTE_IDX_MAX    = 4'hf;
	localparam logic [2:0] LAST_BIT        = 3'h7;
	localparam logic [2:0] NARROW_BYTES    = 3'h2;
	localparam logic [2:0] WIDE_BYTES      = 3'h4;

	// ------------------------------------------------------------------
	// Response buffer
	// ------------------------------------------------------------------
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_IDLE  = 3'b000,
		MODE_ADDR  = 3'b001,
		MODE_RDREG = 3'b010,
		MODE_WRREG = 3'b011,
		MODE_FIFO  = 3'b100,
		MODE_SKIP  = 3'b101
	} ssp_mode_type;

	typedef enum logic [1:0] {
		KIND_READ  = 2'b00,
		KIND_WRITE = 2'b01,
		KIND_FIFO  = 2'b10
	} ssp_kind_type;

	typedef struct packed {
		ssp_kind_type kind;
		logic [15:0]  addr;
		logic [31:0]  wdata;
	} ssp_req_type;

	typedef struct packed {
		logic [1:0]   cs_sync;
		logic [1:0]   sclk_sync;
		logic [1:0]   mosi_sync;
		logic         sclk_prev;
		logic         cs_prev;
		logic [2:0]   bit_cnt;
		logic [3:0]   byte_idx;
		logic [7:0]   rx_sr;
		ssp_mode_type mode;
		logic [7:0]   addr_hi;
		logic         wide;
		logic [31:0]  tx_word;
		logic [2:0]   tx_left;
		logic         miso;
		logic         miso_oe;
		logic [31:0]  buf0;
		logic [31:0]  buf1;
		logic [1:0]   buf_cnt;
		logic         buf_ready;
		logic         pend;
		logic         discard;
		logic         req_valid;
		ssp_req_type  req;
		logic         underflow;
	} ssp_state_type;

endpackage : ssp_pkg

/* verilog/ssp_spi_port.sv */
// Serial command port: byte framing, command decode and read streaming.
//
// Behaviour
// - Chip select high: ignore clock and data.
// - Launch on falling edge, capture on rising.
// - Bytes framed from chip select fall.
// - Bit 7 first, both directions.
// - Chip select rise abandons the transaction.
// - First byte is the command byte.
// - Command 0x20 loads the register address.
// - Command 0x6d reads register at address.
// - Command 0x2d writes register at address.
// - Command 0x5f streams result FIFO words.
// - Address: two bytes, high byte first.
// - Write carries 16 or 32 data bits.
// - Read: dummy byte, then 16/32 bits.
// - Drive read data only in data phase.
// - FIFO data after six dummy bytes, continuous.
// - Prefetch from empty FIFO flags underflow.
`timescale 1ns/100ps

module ssp_spi_port (
	input  wire logic                CORE_CLK,
	input  wire logic                ARST_N,
	input  wire logic                CS_N,
	input  wire logic                SCLK,
	input  wire logic                MOSI,
	output logic                     MISO,
	output logic                     MISO_OE,
	output logic                     REQ_VALID,
	output ssp_pkg::ssp_req_type     REQ,
	input  wire logic                REG_WIDE,
	input  wire logic                FIFO_EMPTY,
	input  wire logic                RSP_VALID,
	input  wire logic [31:0]         RSP_DATA,
	output logic                     RSP_READY,
	output logic                     UNDERFLOW
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	ssp_pkg::ssp_state_type s_q;
	ssp_pkg::ssp_state_type s_d;

	logic        cs_act;
	logic        sclk_rise;
	logic        sclk_fall;
	logic [7:0]  rx_byte;
	logic [31:0] wd_next;
	logic [31:0] head;
	logic        have_head;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// One step of the shifter; the top bit is the next one on the line.
	function automatic logic [31:0] shift_word(
		input logic [31:0] w
	);
		return {w[30:0], 1'b0};
	endfunction : shift_word

	// Byte positions at which a new data word starts in the given mode.
	function automatic logic word_start(
		input ssp_pkg::ssp_mode_type m,
		input logic [3:0]            idx
	);
		return (m == ssp_pkg::MODE_RDREG &&
		        idx == ssp_pkg::READ_DATA_BYTE) ||
		       (m == ssp_pkg::MODE_FIFO &&
		        idx >= ssp_pkg::FIFO_DATA_BYTE);
	endfunction : word_start

	// Last byte of a write data phase for the register's width.
	function automatic logic write_end(
		input logic       wide,
		input logic [3:0] idx
	);
		return wide ? (idx == ssp_pkg::WRITE_WIDE_END) :
		              (idx == ssp_pkg::WRITE_NARROW_END);
	endfunction : write_end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.req_valid = 1'b0;

		// Pins pass two flip-flops; only the second stage is read below.
		s_d.cs_sync   = {s_q.cs_sync[0], CS_N};
		s_d.sclk_sync = {s_q.sclk_sync[0], SCLK};
		s_d.mosi_sync = {s_q.mosi_sync[0], MOSI};
		s_d.sclk_prev = s_q.sclk_sync[1];
		s_d.cs_prev   = s_q.cs_sync[1];

		// Edges are found one stage after the synchroniser, so the serial
		// clock must stay well below the sampling rate.
		cs_act    = !s_q.cs_sync[1];
		sclk_rise = cs_act && s_q.sclk_sync[1] && !s_q.sclk_prev;
		sclk_fall = cs_act && !s_q.sclk_sync[1] && s_q.sclk_prev;
		rx_byte   = {s_q.rx_sr[6:0], s_q.mosi_sync[1]};
		wd_next   = {s_q.req.wdata[23:0], rx_byte};
		head      = s_q.buf0;
		have_head = (s_q.buf_cnt != 2'h0);

		// --------------------------------------------------------------
		// Response buffer fill
		// --------------------------------------------------------------
		if (RSP_VALID && s_q.buf_ready) begin
			s_d.pend = 1'b0;
			if (s_q.discard) begin
				// A late answer to an abandoned request is dropped.
				s_d.discard = 1'b0;
			end else if (s_q.buf_cnt == 2'h0) begin
				s_d.buf0    = RSP_DATA;
				s_d.buf_cnt = 2'h1;
			end else begin
				s_d.buf1    = RSP_DATA;
				s_d.buf_cnt = ssp_pkg::BUF_DEPTH;
			end
		end

		// --------------------------------------------------------------
		// Receive side: capture on rising edge
		// --------------------------------------------------------------
		if (sclk_rise) begin
			s_d.rx_sr   = rx_byte;
			s_d.bit_cnt = s_q.bit_cnt + 3'h1;
			if (s_q.bit_cnt == ssp_pkg::LAST_BIT) begin
				if (s_q.byte_idx != ssp_pkg::BYTE_IDX_MAX) begin
					s_d.byte_idx = s_q.byte_idx + 4'h1;
				end
				if (s_q.byte_idx == 4'h0) begin
					s_d.req.wdata = 32'h0;
					// Width is taken with the command byte; the decode
					// behind the port must have settled by then.
					s_d.wide      = REG_WIDE;
					unique case (rx_byte)
						ssp_pkg::CMD_LOAD_ADDRESS: begin
							s_d.mode = ssp_pkg::MODE_ADDR;
						end
						ssp_pkg::CMD_REGISTER_READ: begin
							s_d.mode      = ssp_pkg::MODE_RDREG;
							s_d.req.kind  = ssp_pkg::KIND_READ;
							s_d.req_valid = !s_q.pend;
							s_d.pend      = 1'b1;
						end
						ssp_pkg::CMD_REGISTER_WRITE: begin
							s_d.mode = ssp_pkg::MODE_WRREG;
						end
						ssp_pkg::CMD_FIFO_STREAM_READ: begin
							s_d.mode = ssp_pkg::MODE_FIFO;
						end
						default: begin
							s_d.mode = ssp_pkg::MODE_SKIP;
						end
					endcase
				end else begin
					unique case (s_q.mode)
						ssp_pkg::MODE_ADDR: begin
							if (s_q.byte_idx == ssp_pkg::ADDR_HIGH_BYTE) begin
								s_d.addr_hi = rx_byte;
							end
							if (s_q.byte_idx == ssp_pkg::ADDR_LOW_BYTE) begin
								s_d.req.addr = {s_q.addr_hi, rx_byte};
							end
						end
						ssp_pkg::MODE_WRREG: begin
							if (s_q.byte_idx <= ssp_pkg::WRITE_WIDE_END) begin
								s_d.req.wdata = wd_next;
							end
							if (write_end(s_q.wide, s_q.byte_idx)) begin
								s_d.req.kind  = ssp_pkg::KIND_WRITE;
								s_d.req.wdata = s_q.wide ? wd_next :
								                {16'h0, wd_next[15:0]};
								s_d.req_valid = 1'b1;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end

		// --------------------------------------------------------------
		// Transmit side: launch on falling edge
		// --------------------------------------------------------------
		if (sclk_fall) begin
			if (s_q.bit_cnt != 3'h0) begin
				s_d.miso    = s_q.tx_word[31];
				s_d.tx_word = shift_word(s_q.tx_word);
			end else if (s_q.tx_left != 3'h0) begin
				s_d.miso    = s_q.tx_word[31];
				s_d.tx_word = shift_word(s_q.tx_word);
				s_d.tx_left = s_q.tx_left - 3'h1;
				s_d.miso_oe = 1'b1;
			end else if (word_start(s_q.mode, s_q.byte_idx)) begin
				// Data phase word boundary: take the buffer head.
				if (s_q.mode == ssp_pkg::MODE_RDREG && !s_q.wide) begin
					s_d.tx_word = {head[15:0], 16'h0};
					s_d.tx_left = ssp_pkg::NARROW_BYTES - 3'h1;
				end else begin
					s_d.tx_word = head;
					s_d.tx_left = ssp_pkg::WIDE_BYTES - 3'h1;
				end
				if (!have_head) begin
					// Not ready in time: the word goes out as zero.
					s_d.tx_word = 32'h0;
				end
				s_d.miso    = have_head && s_d.tx_word[31];
				s_d.tx_word = shift_word(s_d.tx_word);
				s_d.miso_oe = 1'b1;
				if (have_head) begin
					// The second entry is taken as it stands after this
					// cycle's fill, so an answer landing now is kept.
					s_d.buf0    = s_d.buf1;
					s_d.buf_cnt = s_d.buf_cnt - 2'h1;
				end
			end else begin
				s_d.miso    = 1'b0;
				s_d.miso_oe = 1'b0;
			end
		end

		// --------------------------------------------------------------
		// FIFO prefetch keeps the buffer topped up while streaming
		// --------------------------------------------------------------
		// Only one fetch is outstanding at a time; the two entries and the
		// shifter together hide the latency of the answer path.
		if (s_d.mode == ssp_pkg::MODE_FIFO && !s_d.pend &&
		    s_d.buf_cnt != ssp_pkg::BUF_DEPTH && !s_d.req_valid) begin
			s_d.req.kind  = ssp_pkg::KIND_FIFO;
			s_d.req_valid = 1'b1;
			s_d.pend      = 1'b1;
			if (FIFO_EMPTY) begin
				s_d.underflow = 1'b1;
			end
		end

		// --------------------------------------------------------------
		// Chip select framing
		// --------------------------------------------------------------
		if (!cs_act) begin
			// Abandon the frame; the address and underflow flag are kept, an outstanding answer is discarded.
			// A partial byte is dropped as the counters restart with the
			// next select.
			s_d.bit_cnt   = 3'h0;
			s_d.byte_idx  = 4'h0;
			s_d.mode      = ssp_pkg::MODE_IDLE;
			s_d.tx_left   = 3'h0;
			s_d.miso      = 1'b0;
			s_d.miso_oe   = 1'b0;
			s_d.buf_cnt   = 2'h0;
			s_d.req_valid = 1'b0;
			if (s_d.pend && !(RSP_VALID && s_q.buf_ready)) begin
				s_d.discard = 1'b1;
			end
		end else if (s_q.cs_prev) begin
			// Fresh transaction: the error flag restarts with it.
			s_d.underflow = 1'b0;
		end

		s_d.buf_ready = (s_d.buf_cnt != ssp_pkg::BUF_DEPTH);
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			// Synchronisers start at their pins' idle levels, so no false
			// select is seen in the first cycles after reset.
			s_q         <= '0;
			s_q.cs_sync <= 2'h3;
			s_q.cs_prev <= 1'h1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign MISO      = s_q.miso;
	assign MISO_OE   = s_q.miso_oe;
	assign REQ_VALID = s_q.req_valid;
	assign REQ       = s_q.req;
	assign RSP_READY = s_q.buf_ready;
	assign UNDERFLOW = s_q.underflow;

endmodule : ssp_spi_port

/* test/ssp_spi_port_assertions.sv */
// Pin-level assertions of the serial command port.
`timescale 1ns/100ps
module ssp_spi_port_assertions (
	input wire logic                 CORE_CLK, ARST_N, CS_N, SCLK, MISO,
	input wire logic                 MISO_OE, REQ_VALID, FIFO_EMPTY, UNDERFLOW,
	input wire ssp_pkg::ssp_req_type REQ
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);
	property p_idle_quiet; CS_N [*6] |-> !MISO_OE && !REQ_VALID; endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("Port active while deselected");
	property p_req_pulse; REQ_VALID |=> !REQ_VALID; endproperty
	a_req_pulse: assert property (p_req_pulse)
		else $error("Request pulse longer than one cycle");
	property p_req_in_frame; REQ_VALID |-> !CS_N; endproperty
	a_req_in_frame: assert property (p_req_in_frame)
		else $error("Request issued outside a frame");
	property p_oe_drop; $rose(CS_N) |-> ##5 !MISO_OE; endproperty
	a_oe_drop: assert property (p_oe_drop)
		else $error("Data output still driven after deselect");
	// The line may only move a few cycles after a serial clock fall.
	property p_miso_steady; SCLK [*2] |-> $stable(MISO); endproperty
	a_miso_steady: assert property (p_miso_steady)
		else $error("Data output changed while serial clock high");
	property p_uf_set;
		REQ_VALID && REQ.kind == ssp_pkg::KIND_FIFO && FIFO_EMPTY |->
			##[0:2] UNDERFLOW;
	endproperty
	a_uf_set: assert property (p_uf_set)
		else $error("Underflow not flagged on empty fetch");
	property p_uf_clear; $fell(CS_N) |-> ##4 !UNDERFLOW; endproperty
	a_uf_clear: assert property (p_uf_clear)
		else $error("Underflow not cleared by new frame");
	property p_uf_hold; CS_N [*4] ##0 UNDERFLOW |=> UNDERFLOW; endproperty
	a_uf_hold: assert property (p_uf_hold)
		else $error("Underflow flag lost while idle");
endmodule : ssp_spi_port_assertions
bind ssp_spi_port ssp_spi_port_assertions ssp_spi_port_assertions_i (.CORE_CLK,
	.ARST_N, .CS_N, .SCLK, .MISO, .MISO_OE, .REQ_VALID, .FIFO_EMPTY, .UNDERFLOW,
	.REQ);

/* test/ssp_host_model.sv */
// Host master model that frames whole bytes onto the serial command port.
`timescale 1ns/100ps
module ssp_host_model (
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	logic hold = 1'b0;
	logic line;
	// A released line shows the inverse of its last value, so stale data fails.
	assign line = miso_oe ? miso : ~hold;
	always @(miso or miso_oe)
		if (miso_oe)
			hold = miso;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// Half period of 160 ns keeps the link far below the sampling rate.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#160 sclk = 1'b1;
			rx[i] = line;
			#160 sclk = 1'b0;
		end
	endtask : xfer
	task automatic frame(input logic [63:0] d, input int n, input logic close,
		output logic [63:0] got);
		logic [7:0] rx;
		got = '0;
		if (cs_n) begin
			cs_n = 1'b0;
			#160;
		end
		for (int k = 0; k < n; k++) begin
			xfer(d[63 - 8 * k -: 8], rx);
			got = {got[55:0], rx};
		end
		if (close) begin
			#160 cs_n = 1'b1;
			#200;
		end
	endtask : frame
endmodule : ssp_host_model

/* test/ssp_spi_port_tb.sv */
// Self-checking bench of the serial command port with a host master model.
`timescale 1ns/100ps
module ssp_spi_port_tb;
	typedef struct {
		logic [15:0] a;
		logic [31:0] d;
	} ssp_row_type;
	logic                 CORE_CLK = 1'b0;
	logic                 ARST_N = 1'b0;
	logic                 CS_N, SCLK, MOSI, MISO, MISO_OE, REQ_VALID;
	logic                 RSP_READY, UNDERFLOW, w;
	logic                 REG_WIDE = 1'b0;
	logic                 FIFO_EMPTY = 1'b1;
	logic                 RSP_VALID = 1'b0;
	logic [31:0]          RSP_DATA = 32'h0;
	ssp_pkg::ssp_req_type REQ;
	logic [31:0]          regs [logic [15:0]];
	logic [31:0]          fifo [$];
	logic [31:0]          rspq [$];
	logic [31:0]          d;
	logic [63:0]          g;
	logic [7:0]           rx;
	int                   miscompares = 0;
	int                   compares = 0;
	int                   req_cnt = 0;
	int                   cnt0;
	logic [31:0]          words [3] = '{32'hc001_0001, 32'h8e02_3302, 32'h0f03_4403};
	ssp_row_type rows [4] = '{'{16'h2034, 32'h000a_bc12},
		'{16'h0404, 32'h0000_1234}, '{16'h2038, 32'h8000_0001},
		'{16'h0010, 32'h0000_ffff}};
	always #20 CORE_CLK = ~CORE_CLK;
	ssp_spi_port ssp_spi_port_i (.CORE_CLK, .ARST_N, .CS_N, .SCLK, .MOSI, .MISO,
		.MISO_OE, .REQ_VALID, .REQ, .REG_WIDE, .FIFO_EMPTY, .RSP_VALID,
		.RSP_DATA, .RSP_READY, .UNDERFLOW);
	ssp_host_model ssp_host_model_i (.cs_n(CS_N), .sclk(SCLK), .mosi(MOSI),
		.miso(MISO), .miso_oe(MISO_OE));
	// Device side behind the port: register file and result store.
	always @(posedge CORE_CLK) begin
		if (RSP_VALID && RSP_READY)
			void'(rspq.pop_front());
		if (REQ_VALID) begin
			req_cnt++;
			if (REQ.kind == ssp_pkg::KIND_WRITE)
				regs[REQ.addr] = REQ.wdata;
			else if (REQ.kind == ssp_pkg::KIND_READ)
				rspq.push_back(regs[REQ.addr]);
			else
				rspq.push_back(fifo.size() ? fifo.pop_front() : 32'hdead_beef);
		end
	end
	always @(negedge CORE_CLK) begin
		RSP_VALID <= rspq.size() != 0;
		RSP_DATA <= rspq.size() ? rspq[0] : 32'h0;
		FIFO_EMPTY <= fifo.size() == 0;
		REG_WIDE <= REQ.addr[13];
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic send(input logic [63:0] v, input int n, input logic close);
		ssp_host_model_i.frame(v, n, close, g);
	endtask : send
	task automatic set_addr(input logic [15:0] a);
		send({ssp_pkg::CMD_LOAD_ADDRESS, a, 40'h0}, 3, 1'b1);
	endtask : set_addr
	task automatic report_and_stop();
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#1000000;
		miscompares++;
		$display("Error %0t: watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		repeat (16) @(negedge CORE_CLK);
		check({28'h0, MISO_OE, REQ_VALID, UNDERFLOW, RSP_READY}, 32'h0);
		ARST_N = 1'b1;
		repeat (4) @(negedge CORE_CLK);
		check({31'h0, RSP_READY}, 32'h1);
		foreach (rows[i]) begin
			w = rows[i].a[13];
			d = rows[i].d;
			set_addr(rows[i].a);
			send({ssp_pkg::CMD_REGISTER_WRITE, w ? d : {d[15:0], 16'h0}, 24'h0},
				w ? 5 : 3, 1'b1);
			check(regs[rows[i].a], d);
			send({ssp_pkg::CMD_REGISTER_READ, 56'h0}, w ? 6 : 4, 1'b1);
			check(w ? g[31:0] : {16'h0, g[15:0]}, d);
		end
		set_addr(16'h0010);
		cnt0 = req_cnt;
		send({ssp_pkg::CMD_REGISTER_WRITE, 32'h5a3c_1122, 24'h0}, 5, 1'b1);
		send({ssp_pkg::CMD_REGISTER_WRITE, 8'h77, 48'h0}, 2, 1'b1);
		send({8'ha5, 8'h2d, 8'h12, 8'h34, 32'h0}, 4, 1'b1);
		ssp_host_model_i.xfer(ssp_pkg::CMD_REGISTER_WRITE, rx);
		check(req_cnt - cnt0, 32'h1);
		check(regs[16'h0010], 32'h0000_5a3c);
		send({ssp_pkg::CMD_REGISTER_READ, 56'h0}, 4, 1'b1);
		check({16'h0, g[15:0]}, 32'h0000_5a3c);
		foreach (words[k])
			fifo.push_back(words[k]);
		send({ssp_pkg::CMD_FIFO_STREAM_READ, 56'h0}, 7, 1'b0);
		for (int k = 0; k < 3; k++) begin
			send(64'h0, 4, k == 2);
			check(g[31:0], words[k]);
		end
		check({31'h0, UNDERFLOW}, 32'h1);
		set_addr(16'h0404);
		check({31'h0, UNDERFLOW}, 32'h0);
		report_and_stop();
	end
endmodule : ssp_spi_port_tb
